// ### src/rps_consts.svh
// timing counts, reset values and field positions for the reset sequencer
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
`define RPS_CLK_MHZ          40
`define RPS_POR_DELAY_LO_MS  7
`define RPS_POR_DELAY_HI_MS  15
`define RPS_POR_LO_CYC       (`RPS_POR_DELAY_LO_MS * `RPS_CLK_MHZ * 1000)
`define RPS_POR_HI_CYC       (`RPS_POR_DELAY_HI_MS * `RPS_CLK_MHZ * 1000)
`define RPS_WDT_DIV          12
`define RPS_PORT_RESET       8'hFF
`define RPS_PC_RESET         16'h0000
`define RPS_SRC_W            8
`define RPS_POWER_ON_RESET_FLAG_BIT        1
`define RPS_POR_MONITOR_DISABLE_BIT       5
`define RPS_SRC_PIN_BIT      0
`define RPS_SRC_MON_BIT      2
`define RPS_SRC_SW_BIT       4
`endif

// ### src/rps_delay_cnt.sv
// down counter timing the power-on release delay
`timescale 1ns/100ps
`default_nettype none
module rps_delay_cnt #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    logic [W-1:0] cnt_ff;     // remaining cycles

    // reload while held, else count to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // done once the count has run out
    assign done = (cnt_ff == '0) && !load;
endmodule
`default_nettype wire

// ### src/rps_pkg.sv
// types for the reset sequencer
package rps_pkg;
    typedef enum logic [1:0] {
        RPS_ST_POR_HOLD,
        RPS_ST_POR_WAIT,
        RPS_ST_RUN,
        RPS_ST_RST_HOLD
    } rps_state_type;
endpackage

// ### src/rps_sequencer.sv
// reset and power-on sequencer core
// Overview of operation
// R01: reset halts core, resets registers, ports, timers
// R02: ram untouched; only stack pointer reinitialised
// R03: port latches all ones, open drain
// R04: pull-ups off in reset, on after
// R05: monitor reset drives reset pin low
// R06: exit clears pc, internal oscillator, fetch zero
// R07: watchdog enabled on clock divided by twelve
// R08: hold reset while supply powers up
// R09: wait release delay after power threshold
// R10: set power-on flag leaving power-on reset
// R11: other resets clear power-on flag
// R12: software treats ram undefined after power-on
// R13: power-on monitor watches supply in sleep
// R14: software write disables power-on monitor
// R15: monitor disabled: any reset is full power-on
// R16: supply back above threshold releases core
// R17: cause flags captured at release, held stable
`timescale 1ns/100ps
`default_nettype none
`include "rps_consts.svh"
module rps_sequencer #(
    parameter int unsigned POR_DELAY_CYC = `RPS_POR_LO_CYC,
    parameter int unsigned POR_DELAY_HI  = `RPS_POR_HI_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        supply_above_por,
    input  wire logic        supply_above_mon,
    input  wire logic        supply_high_range,
    input  wire logic        mon_enable,
    input  wire logic        ext_reset_n,
    input  wire logic        sw_reset,
    input  wire logic        mode_wr,
    input  wire logic [7:0]  mode_wdata,
    output logic             core_reset,
    output logic             sp_reset,
    output logic             ram_keep,
    output logic [7:0]       port_latch,
    output logic             port_open_drain,
    output logic             pullup_en,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic [15:0]      pc_init,
    output logic             clk_sel_internal,
    output logic             wdt_en,
    output logic [3:0]       wdt_div,
    output logic [7:0]       reset_source_register,
    output logic             por_monitor_disable
);
    // two-flop synchronisers for the analog and pin inputs
    logic [3:0] s1_ff;          // first stage
    logic [3:0] s2_ff;          // second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            // pin bit parks at its idle high level, supplies read low
            s1_ff <= 4'h1;
            s2_ff <= 4'h1;
        end else begin
            s1_ff <= {supply_above_por, supply_above_mon,
                      supply_high_range, ext_reset_n};
            s2_ff <= s1_ff;
        end
    end
    logic por_ok;               // supply above power-on threshold
    logic mon_ok;               // supply above monitor threshold
    logic hi_rng;               // high supply range
    logic pin_n;                // reset pin level
    assign por_ok = s2_ff[3];
    assign mon_ok = s2_ff[2];
    assign hi_rng = s2_ff[1];
    assign pin_n  = s2_ff[0];

    rps_pkg::rps_state_type state_ff;     // sequencer state
    rps_pkg::rps_state_type nxt_state;    // next state
    logic por_monitor_disable_ff;            // power-on monitor disabled
    logic por_cause_ff;         // pending cause: power-on
    logic [`RPS_SRC_W-1:0] cause_ff;      // pending other causes
    logic [`RPS_SRC_W-1:0] src_ff;        // captured cause register
    logic mon_rst_ff;           // reset caused by supply monitor
    logic dly_load;             // reload release timer
    logic dly_done;             // release timer expired
    logic [31:0] dly_val;       // delay for this supply range

    // pick delay by supply range
    assign dly_val = hi_rng ? 32'(POR_DELAY_HI) : 32'(POR_DELAY_CYC); // [R09]
    assign dly_load = (state_ff != rps_pkg::RPS_ST_POR_WAIT);

    rps_delay_cnt #(.W(32)) u_dly (
        .clk      (clk),
        .rst      (rst),
        .load     (dly_load),
        .load_val (dly_val),
        .done     (dly_done)
    );

    logic mon_fail;             // monitor reset condition
    logic other_src;            // pin or software reset
    assign mon_fail  = mon_enable && !mon_ok;
    assign other_src = !pin_n || sw_reset;

    // state transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rps_pkg::RPS_ST_POR_HOLD: begin
                if (por_ok) begin
                    nxt_state = rps_pkg::RPS_ST_POR_WAIT; // [R08]
                end
            end
            rps_pkg::RPS_ST_POR_WAIT: begin
                if (!por_ok) begin
                    nxt_state = rps_pkg::RPS_ST_POR_HOLD;
                end else if (dly_done) begin
                    nxt_state = rps_pkg::RPS_ST_RUN; // [R09]
                end
            end
            rps_pkg::RPS_ST_RUN: begin
                // a disabled power-on monitor lets a supply dip pass
                if (!por_ok && !por_monitor_disable_ff) begin
                    nxt_state = rps_pkg::RPS_ST_POR_HOLD; // [R13] [R14]
                end else if ((mon_fail || other_src) && por_monitor_disable_ff) begin
                    nxt_state = rps_pkg::RPS_ST_POR_HOLD; // [R15]
                end else if (mon_fail || other_src) begin
                    nxt_state = rps_pkg::RPS_ST_RST_HOLD;
                end
            end
            rps_pkg::RPS_ST_RST_HOLD: begin
                if (!por_ok) begin
                    nxt_state = rps_pkg::RPS_ST_POR_HOLD;
                end else if (!mon_fail && !other_src) begin
                    nxt_state = rps_pkg::RPS_ST_RUN; // [R16]
                end
            end
            default: begin
                nxt_state = rps_pkg::RPS_ST_POR_HOLD;
            end
        endcase
    end

    // state register; power-on hold after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= rps_pkg::RPS_ST_POR_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic in_reset;             // any reset state
    logic release_evt;          // leaving reset this cycle
    assign in_reset    = (state_ff != rps_pkg::RPS_ST_RUN);
    assign release_evt = in_reset && (nxt_state == rps_pkg::RPS_ST_RUN);

    // monitor disable bit; power-on re-enables it
    always_ff @(posedge clk) begin
        if (rst) begin
            por_monitor_disable_ff <= 1'b0;
        end else if (state_ff == rps_pkg::RPS_ST_POR_HOLD) begin
            por_monitor_disable_ff <= 1'b0; // [R15]
        end else if (mode_wr && !in_reset) begin
            por_monitor_disable_ff <= mode_wdata[`RPS_POR_MONITOR_DISABLE_BIT]; // [R14]
        end
    end

    // pending causes sampled while running; power-on hold sets the power-on cause
    always_ff @(posedge clk) begin
        if (rst) begin
            por_cause_ff <= 1'b1;
            cause_ff     <= '0;
            mon_rst_ff   <= 1'b0;
        end else if (state_ff == rps_pkg::RPS_ST_POR_HOLD) begin
            por_cause_ff <= 1'b1;
            cause_ff     <= '0;
            mon_rst_ff   <= 1'b0;
        end else if (state_ff == rps_pkg::RPS_ST_RUN) begin
            por_cause_ff <= 1'b0; // [R11]
            cause_ff <= '0;
            cause_ff[`RPS_SRC_PIN_BIT] <= !pin_n;
            cause_ff[`RPS_SRC_MON_BIT] <= mon_fail;
            cause_ff[`RPS_SRC_SW_BIT]  <= sw_reset;
            mon_rst_ff <= mon_fail;
        end else if (state_ff == rps_pkg::RPS_ST_RST_HOLD) begin
            mon_rst_ff <= mon_rst_ff || mon_fail;
        end
    end

    // cause register captured at release, stable afterward
    always_ff @(posedge clk) begin
        if (rst) begin
            src_ff <= '0;
        end else if (release_evt) begin
            src_ff <= cause_ff; // [R17]
            src_ff[`RPS_POWER_ON_RESET_FLAG_BIT] <= por_cause_ff; // [R10] [R11]
        end
    end

    // reset-state outputs toward core and ports
    always_comb begin
        core_reset      = in_reset; // [R01]
        sp_reset        = in_reset; // [R02]
        ram_keep        = 1'b1; // [R02]
        port_latch      = in_reset ? `RPS_PORT_RESET : 8'hFF; // [R03]
        port_open_drain = in_reset; // [R03]
        pullup_en       = !in_reset; // [R04]
        reset_pin_out   = 1'b0;
        reset_pin_oe    = (state_ff == rps_pkg::RPS_ST_RST_HOLD)
                          && mon_rst_ff; // [R05]
        pc_init          = `RPS_PC_RESET; // [R06]
        clk_sel_internal = 1'b1; // [R06]
        wdt_en           = !in_reset; // [R07]
        wdt_div          = 4'(`RPS_WDT_DIV); // [R07]
        reset_source_register = src_ff;
        por_monitor_disable   = por_monitor_disable_ff; // [R14]
    end

    // checks
    int unsigned hold_cnt_ff;   // cycles spent in power-on wait
    always_ff @(posedge clk) begin
        if (rst || state_ff != rps_pkg::RPS_ST_POR_WAIT) begin
            hold_cnt_ff <= 0;
        end else begin
            hold_cnt_ff <= hold_cnt_ff + 1;
        end
    end

    release_delay_a: assert property (@(posedge clk) disable iff (rst) // [R09]
        (state_ff == rps_pkg::RPS_ST_POR_WAIT
         && nxt_state == rps_pkg::RPS_ST_RUN)
        |-> hold_cnt_ff + 1 >= POR_DELAY_CYC)
        else $error("released before delay");
    hold_por_a: assert property (@(posedge clk) disable iff (rst) // [R08]
        (!por_ok && !por_monitor_disable_ff)
        |=> core_reset)
        else $error("core not held with supply low");
    power_on_reset_flag_set_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        (release_evt && por_cause_ff)
        |=> reset_source_register[`RPS_POWER_ON_RESET_FLAG_BIT])
        else $error("power-on flag not set");
    power_on_reset_flag_clear_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        (state_ff == rps_pkg::RPS_ST_RST_HOLD && release_evt)
        |=> !reset_source_register[`RPS_POWER_ON_RESET_FLAG_BIT])
        else $error("power-on flag not cleared");
    pullup_off_a: assert property (@(posedge clk) disable iff (rst) // [R04]
        core_reset |-> !pullup_en && port_open_drain)
        else $error("pull-up on during reset");
    pin_drive_a: assert property (@(posedge clk) disable iff (rst) // [R05]
        (state_ff == rps_pkg::RPS_ST_RUN && mon_fail && por_ok
         && !por_monitor_disable_ff) |=> reset_pin_oe)
        else $error("reset pin not driven");
    mon_release_a: assert property (@(posedge clk) disable iff (rst) // [R16]
        (state_ff == rps_pkg::RPS_ST_RST_HOLD && por_ok && !mon_fail
         && !other_src) |=> !core_reset)
        else $error("not released after recovery");
    full_por_a: assert property (@(posedge clk) disable iff (rst) // [R15]
        (state_ff == rps_pkg::RPS_ST_RUN && por_monitor_disable_ff && other_src)
        |=> state_ff == rps_pkg::RPS_ST_POR_HOLD ##1 !por_monitor_disable)
        else $error("no full power-on sequence");
    src_stable_a: assert property (@(posedge clk) disable iff (rst) // [R17]
        (!in_reset && !$past(in_reset)) |-> $stable(reset_source_register))
        else $error("cause register changed");
    wdt_on_a: assert property (@(posedge clk) disable iff (rst) // [R07]
        !core_reset |-> wdt_en && wdt_div == 4'(`RPS_WDT_DIV))
        else $error("watchdog setup wrong");

    // a write during reset must not touch the disable bit
    mode_refused_a: assert property (@(posedge clk) disable iff (rst) // [R14]
        (mode_wr && in_reset && state_ff != rps_pkg::RPS_ST_POR_HOLD)
        |=> $stable(por_monitor_disable))
        else $error("mode write taken in reset");
    // ports parked all ones, open drain, while held
    port_park_a: assert property (@(posedge clk) disable iff (rst) // [R03]
        core_reset |-> port_latch == `RPS_PORT_RESET && port_open_drain)
        else $error("ports not parked in reset");
    // boot state presented whenever the core runs
    boot_state_a: assert property (@(posedge clk) disable iff (rst) // [R06]
        !core_reset |-> pc_init == `RPS_PC_RESET && clk_sel_internal)
        else $error("boot state wrong");
    // memory kept and stack pointer reset during any hold
    ram_keep_a: assert property (@(posedge clk) disable iff (rst) // [R02]
        core_reset |-> ram_keep && sp_reset)
        else $error("ram not kept in reset");
    // a disabled monitor lets a supply dip pass
    mon_off_a: assert property (@(posedge clk) disable iff (rst) // [R14]
        (state_ff == rps_pkg::RPS_ST_RUN && por_monitor_disable_ff && !por_ok
         && !mon_fail && !other_src) |=> !core_reset)
        else $error("disabled monitor still resets");
    // reset pin never driven while the core runs
    pin_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R05]
        !core_reset |-> !reset_pin_oe)
        else $error("reset pin driven while running");
    // watchdog held off during any hold
    wdt_off_a: assert property (@(posedge clk) disable iff (rst) // [R01]
        core_reset |-> !wdt_en)
        else $error("watchdog on during reset");

    // main scenarios seen at least once
    por_release_c: cover property (@(posedge clk) disable iff (rst)
        release_evt && por_cause_ff);
    mon_reset_c: cover property (@(posedge clk) disable iff (rst)
        reset_pin_oe ##1 !reset_pin_oe);
    disable_c: cover property (@(posedge clk) disable iff (rst)
        por_monitor_disable ##1 state_ff == rps_pkg::RPS_ST_POR_HOLD);
    sw_reset_c: cover property (@(posedge clk) disable iff (rst)
        state_ff == rps_pkg::RPS_ST_RUN && sw_reset
        ##1 state_ff == rps_pkg::RPS_ST_RST_HOLD);
    power_dip_c: cover property (@(posedge clk) disable iff (rst)
        state_ff == rps_pkg::RPS_ST_RUN && !por_ok
        ##1 state_ff == rps_pkg::RPS_ST_POR_HOLD);
endmodule
`default_nettype wire

// ### testbench/reset_and_power_on_sequencer_bench.sv
// self-checking bench for the reset and power-on sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_and_power_on_sequencer_bench;
    localparam int D  = 20;  // short power-on delay
    localparam int DH = 40;  // long power-on delay
    logic clk, rst, s_por, s_mon, s_hi, mon_en, ext_n, sw_req, m_wr;
    logic [7:0]  m_wd;                    // mode register data
    logic        core_reset, sp_reset, ram_keep, port_open_drain;
    logic        pullup_en, reset_pin_out, reset_pin_oe, clk_sel_internal;
    logic        wdt_en, por_monitor_disable, sw_reset, boot_ok, por_seen;
    logic [7:0]  port_latch, reset_source_register;
    logic [15:0] pc_init;
    logic [3:0]  wdt_div;
    int          errors, compares, n;

    rps_sequencer #(.POR_DELAY_CYC(D), .POR_DELAY_HI(DH)) uut (
        .clk, .rst, .supply_above_por(s_por), .supply_above_mon(s_mon),
        .supply_high_range(s_hi), .mon_enable(mon_en), .ext_reset_n(ext_n),
        .sw_reset, .mode_wr(m_wr), .mode_wdata(m_wd), .core_reset,
        .sp_reset, .ram_keep, .port_latch, .port_open_drain, .pullup_en,
        .reset_pin_out, .reset_pin_oe, .pc_init, .clk_sel_internal,
        .wdt_en, .wdt_div, .reset_source_register, .por_monitor_disable);

    rps_core_model core (
        .clk, .core_reset, .pc_init, .clk_sel_internal, .wdt_en, .wdt_div,
        .reset_source_register, .sw_req, .sw_reset,
        .boot_ok_ff(boot_ok), .por_seen_ff(por_seen));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // step c edges, then drive just after the edge
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask

    // compare one value, count and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for core_reset to reach lvl, cycles in n
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (core_reset !== lvl) begin
            if (n >= lim) begin
                errors++;
                test_done;
            end
            cyc(1);
            n++;
        end
    endtask

    // counts and verdict
    task automatic test_done;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // supply drop then ramp; hi picks the long delay d
    task automatic t_power_on(input logic hi, input int d);
        s_por = 1'b0;
        s_hi = hi;
        wait_rst(1'b1, 6);
        cyc(4);
        chk(sp_reset, 1'b1);
        chk(ram_keep, 1'b1);
        chk({pullup_en, port_open_drain, wdt_en}, 3'b010);
        chk(port_latch, 8'hFF);
        s_por = 1'b1;
        wait_rst(1'b0, d + 8);
        chk(n >= d, 1'b1);
        chk(pullup_en, 1'b1);
        cyc(1);
        chk(boot_ok, 1'b1);
        chk(por_seen, 1'b1);
    endtask

    // software reset: quick release, power-on flag cleared
    task automatic t_sw;
        sw_req = 1'b1;
        wait_rst(1'b1, 6);
        sw_req = 1'b0;
        wait_rst(1'b0, 8);
        chk(reset_source_register, 8'h10);
        cyc(12);
        chk(reset_source_register, 8'h10);
        chk(por_seen, 1'b0);
    endtask

    // monitor reset drives the pin until the supply returns
    task automatic t_mon;
        mon_en = 1'b0;
        s_mon = 1'b0;
        cyc(6);
        chk(core_reset, 1'b0);
        mon_en = 1'b1;
        wait_rst(1'b1, 6);
        cyc(1);
        chk({reset_pin_oe, reset_pin_out}, 2'b10);
        cyc(D + 5);
        chk(core_reset, 1'b1);
        s_mon = 1'b1;
        wait_rst(1'b0, 8);
        chk(reset_pin_oe, 1'b0);
        chk(reset_source_register, 8'h04);
    endtask

    // pin reset: pin not driven, cause recorded
    task automatic t_pin;
        ext_n = 1'b0;
        wait_rst(1'b1, 6);
        cyc(3);
        chk(reset_pin_oe, 1'b0);
        m_wd = 8'h20;
        m_wr = 1'b1;
        cyc(1);
        m_wr = 1'b0;
        ext_n = 1'b1;
        wait_rst(1'b0, 8);
        chk(reset_source_register, 8'h01);
        chk(por_monitor_disable, 1'b0);
    endtask

    // monitor disabled: a pin reset becomes a full power-on
    task automatic t_disable;
        m_wd = 8'h20;
        m_wr = 1'b1;
        cyc(1);
        m_wr = 1'b0;
        cyc(1);
        chk(por_monitor_disable, 1'b1);
        s_por = 1'b0;
        cyc(5);
        chk(core_reset, 1'b0);
        s_por = 1'b1;
        cyc(3);
        ext_n = 1'b0;
        wait_rst(1'b1, 6);
        cyc(2);
        ext_n = 1'b1;
        wait_rst(1'b0, D + 12);
        chk(n >= D, 1'b1);
        chk(por_monitor_disable, 1'b0);
        chk(reset_source_register[1], 1'b1);
    endtask

    // main sequence
    initial begin
        {errors, compares} = '0;
        {s_por, s_hi, sw_req, m_wr, m_wd} = '0;
        {rst, s_mon, mon_en, ext_n} = 4'hF;
        cyc(8);
        rst = 1'b0;
        t_power_on(1'b0, D);
        t_sw;
        t_mon;
        t_pin;
        t_disable;
        t_power_on(1'b1, DH);
        test_done;
    end
endmodule
`default_nettype wire

// ### testbench/rps_core_model.sv
// core-side model: checks the boot state and reads the power-on flag
`timescale 1ns/100ps
`default_nettype none
module rps_core_model (
    input  wire logic        clk,
    input  wire logic        core_reset,
    input  wire logic [15:0] pc_init,
    input  wire logic        clk_sel_internal,
    input  wire logic        wdt_en,
    input  wire logic [3:0]  wdt_div,
    input  wire logic [7:0]  reset_source_register,
    input  wire logic        sw_req,
    output logic             sw_reset,
    output logic             boot_ok_ff,
    output logic             por_seen_ff
);
    logic was_rst_ff;  // core_reset one edge ago

    // software can only ask for a reset while it runs
    assign sw_reset = sw_req & ~core_reset;

    // remember reset level to find the release edge
    always_ff @(posedge clk) begin
        was_rst_ff <= core_reset;
    end

    // at release: fetch from zero, internal clock, watchdog on
    always_ff @(posedge clk) begin
        if (was_rst_ff && !core_reset) begin
            boot_ok_ff <= (pc_init == 16'h0000) && clk_sel_internal
                && wdt_en && (wdt_div == 4'hC);
        end
    end

    // software reads the power-on flag to tell the cause
    always_ff @(posedge clk) begin
        if (was_rst_ff && !core_reset) begin
            por_seen_ff <= reset_source_register[1];
        end
    end
endmodule
`default_nettype wire
